// ===== rtl/cesw_map.vh
// Constants for the execution, sequencing and sleep/wake controller.
// Included by every design file except the decoder; holds definitions only.
`ifndef CESW_MAP_VH
`define CESW_MAP_VH

// ****************************************************************
// Register offsets (APB byte addresses)
// ****************************************************************
`define CESW_OFF_CTRL     12'h000
`define CESW_OFF_STATUS   12'h004
`define CESW_OFF_IRQ_STAT 12'h008
`define CESW_OFF_IRQ_MASK 12'h00C
`define CESW_OFF_INSTR    12'h010
`define CESW_OFF_WREG     12'h014
`define CESW_OFF_PC       12'h018
`define CESW_OFF_IDADDR   12'h01C
`define CESW_OFF_IDDATA   12'h020
`define CESW_OFF_PGMADDR  12'h024
`define CESW_OFF_PGMDATA  12'h028

// ****************************************************************
// Control register fields
// ****************************************************************
`define CESW_CTRL_RUN     0
`define CESW_CTRL_GIE     1
`define CESW_CTRL_PGMMODE 2
`define CESW_CTRL_CP      3
`define CESW_CTRL_RESET   32'h0000_0000

// ****************************************************************
// Status / interrupt fields
// ****************************************************************
`define CESW_ST_TO    0
`define CESW_ST_PD    1
`define CESW_ST_SLEEP 2
`define CESW_IRQ_WAKE  0
`define CESW_IRQ_SLEEP 1
`define CESW_IRQ_NOPSL 2
`define CESW_IRQ_W     3

// ****************************************************************
// Identity and vector addresses
// ****************************************************************
`define CESW_ID_BASE   14'h2000
`define CESW_ID_LAST   14'h2003
`define CESW_INT_VEC   13'h0004

// ****************************************************************
// Timing
// ****************************************************************
`define CESW_OSC_PER_CYCLE 4

`endif

// ===== rtl/cesw_phase_gen.v
// Quarter-phase generator: divides the oscillator into instruction cycles.
// Assumes mclk is the oscillator; halts when the driver is turned off.
`timescale 1ns/1ps
`default_nettype none
`include "cesw_map.vh"

module cesw_phase_gen #(
    parameter PERIODS = `CESW_OSC_PER_CYCLE
) (
    input wire mclk,
    input wire nrst,
    input wire osc_on,
    output reg [1:0] phase_reg,
    output wire cycle_end
);
    // Sleep holds the count so the first cycle after wake is a full one.
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            phase_reg <= 2'd0;
        end else if (osc_on) begin
            phase_reg <= (phase_reg == PERIODS - 1) ? 2'd0 : phase_reg + 2'd1;
        end
    end
    assign cycle_end = osc_on && (phase_reg == PERIODS - 1);
endmodule
`default_nettype wire

// ===== rtl/cesw_decode.v
// Instruction word field decoder for the 14-bit core.
// Assumes the word is stable for the whole instruction cycle.
`timescale 1ns/1ps
`default_nettype none

module cesw_decode (
    input wire [13:0] instr,
    output wire [1:0] category,
    output wire dest_sel,
    output wire [6:0] file_addr,
    output wire [2:0] bit_sel,
    output wire [7:0] lit8,
    output wire [10:0] lit11,
    output wire is_sleep,
    output wire is_watchdog_clear_instruction,
    output wire is_clrf,
    output wire is_goto_call,
    output wire is_return,
    output wire is_skip_byte,
    output wire is_skip_bit,
    output wire names_file
);
    assign category = instr[13:12];
    assign dest_sel = instr[7];
    assign file_addr = instr[6:0];
    assign bit_sel = instr[9:7];
    assign lit8 = instr[7:0];
    assign lit11 = instr[10:0];
    assign is_sleep = (instr == 14'h0063);
    assign is_watchdog_clear_instruction = (instr == 14'h0064);
    assign is_clrf = (instr[13:7] == 7'b0000011);
    assign is_goto_call = (instr[13:12] == 2'b10);
    assign is_return = (instr == 14'h0008) || (instr == 14'h0009) ||
                       (instr[13:10] == 4'b1101);
    assign is_skip_byte = (instr[13:8] == 6'b001011) || (instr[13:8] == 6'b001111);
    assign is_skip_bit = (instr[13:11] == 3'b011);
    assign names_file = (instr[13:12] == 2'b01) ||
                        ((instr[13:12] == 2'b00) && (instr[13:8] != 6'b000000 || instr[7]));
endmodule
`default_nettype wire

// ===== rtl/cesw_core_ctrl.v
// Execution sequencer with sleep/wake control and an APB register slave.
// Assumes program memory and file registers answer combinationally.
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "cesw_map.vh"

// What this block does
// - Pending enabled flag with GLOBAL_INTERRUPT_ENABLE off: sleep is no-op
// - Flag during sleep: finish sleep, then wake
// - Four ID words, reachable only in program mode
// - Unprotected program memory readable for verification
// - Every instruction is a 14-bit word
// - Destination bit picks accumulator or file register
// - Bit field selects bit of file register
// - Literal is eight or eleven bits
// - Instruction cycle spans four oscillator periods
// - Skip or branch takes two cycles, second idle
// - File operands read, modify, then store, except bit tests, which only read
// - Clearing upper port refreshes change reference
// - Enabled source wakes regardless of GLOBAL_INTERRUPT_ENABLE
// - Sleep stops the instruction clock
// - Sleep prefetches the next instruction
module cesw_core_ctrl #(
    parameter PC_W = 13,
    parameter UPPER_PORT_ADDR = 7'h06
) (
    input wire mclk,
    input wire nrst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    output wire irq,
    input wire [13:0] pgm_rdata,
    output reg [PC_W-1:0] pgm_addr_reg,
    input wire [7:0] file_rdata,
    output reg [6:0] file_addr_reg,
    output reg [7:0] file_wdata_reg,
    output reg file_we_reg,
    output reg file_re_reg,
    output reg port_ref_update_reg,
    input wire [7:0] int_enable_flags,
    input wire [7:0] int_pending_flags,
    output reg watchdog_clear_reg,
    output reg osc_driver_on_reg
);
    // ****************************************************************
    // Declarations
    // ****************************************************************
    localparam ST_RUN = 2'd0;
    localparam ST_IDLE = 2'd1;
    localparam ST_SLEEP = 2'd2;
    localparam ST_DUMMY = 2'd3;

    reg [31:0] ctrl_reg;
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [13:0] instr_reg;
    reg [PC_W-1:0] pc_reg;
    reg [7:0] wreg_reg;
    reg timeout_status_bit_reg;
    reg powerdown_status_bit_reg;
    reg [3:0] irq_stat_reg;
    reg [3:0] irq_mask_reg;
    reg [3:0] id_mem [0:3];
    reg [1:0] id_addr_reg;
    reg [PC_W-1:0] pgm_peek_reg;
    reg vector_pending_reg;
    reg [1:0] dummy_cnt_reg;
    reg irq_sampled_reg;
    reg [7:0] alu_res;
    reg [3:0] ev_set;
    wire [1:0] phase;
    wire cycle_end;
    wire [1:0] category;
    wire dest_sel;
    wire [6:0] f_addr;
    wire [2:0] bit_sel;
    wire [7:0] lit8;
    wire [10:0] lit11;
    wire is_sleep, is_watchdog_clear_instruction, is_clrf, is_goto_call, is_return;
    wire is_skip_byte, is_skip_bit, names_file;
    wire wr_en, rd_en, mapped;
    wire any_pending;
    wire skip_taken, pc_change;
    wire pgm_mode;
    integer i;

    function [7:0] bit_mask;
        input [2:0] sel;
        begin
            bit_mask = 8'h01 << sel;
        end
    endfunction

    // ****************************************************************
    // Submodules
    // ****************************************************************
    cesw_phase_gen #(.PERIODS(`CESW_OSC_PER_CYCLE)) u_phase (
        .mclk(mclk),
        .nrst(nrst),
        .osc_on(osc_driver_on_reg),
        .phase_reg(phase),
        .cycle_end(cycle_end)
    );

    cesw_decode u_dec (
        .instr(instr_reg),
        .category(category),
        .dest_sel(dest_sel),
        .file_addr(f_addr),
        .bit_sel(bit_sel),
        .lit8(lit8),
        .lit11(lit11),
        .is_sleep(is_sleep),
        .is_watchdog_clear_instruction(is_watchdog_clear_instruction),
        .is_clrf(is_clrf),
        .is_goto_call(is_goto_call),
        .is_return(is_return),
        .is_skip_byte(is_skip_byte),
        .is_skip_bit(is_skip_bit),
        .names_file(names_file)
    );

    // ****************************************************************
    // Execution helpers
    // ****************************************************************
    assign pgm_mode = ctrl_reg[`CESW_CTRL_PGMMODE];
    assign any_pending = |(int_enable_flags & int_pending_flags);
    assign skip_taken = (is_skip_byte && (alu_res == 8'h00)) ||
                        (is_skip_bit && (file_rdata[bit_sel] == instr_reg[10]));
    assign pc_change = is_goto_call || is_return || skip_taken;

    // Result of the read-modify step for byte and bit operations.
    always @* begin
        alu_res = file_rdata;
        if (category == 2'b01) begin
            if (instr_reg[11:10] == 2'b00) begin
                alu_res = file_rdata & ~bit_mask(bit_sel);
            end else if (instr_reg[11:10] == 2'b01) begin
                alu_res = file_rdata | bit_mask(bit_sel);
            end
        end else if (category == 2'b00) begin
            case (instr_reg[11:8])
                4'h0: alu_res = wreg_reg;
                4'h1: alu_res = 8'h00;
                4'h3, 4'hB: alu_res = file_rdata - 8'h01;
                4'hA, 4'hF: alu_res = file_rdata + 8'h01;
                4'h4: alu_res = file_rdata | wreg_reg;
                4'h5: alu_res = file_rdata & wreg_reg;
                4'h6: alu_res = file_rdata ^ wreg_reg;
                4'h7: alu_res = file_rdata + wreg_reg;
                4'h2: alu_res = file_rdata - wreg_reg;
                4'h9: alu_res = ~file_rdata;
                4'hE: alu_res = {file_rdata[3:0], file_rdata[7:4]};
                default: alu_res = file_rdata;
            endcase
        end
    end

    // ****************************************************************
    // Sequencer state
    // ****************************************************************
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_RUN: begin
                if (cycle_end && !pgm_mode && ctrl_reg[`CESW_CTRL_RUN]) begin
                    if (is_sleep && !irq_sampled_reg) begin
                        state_next = ST_SLEEP;
                    end else if (pc_change) begin
                        state_next = ST_IDLE;
                    end
                end
            end
            ST_IDLE: if (cycle_end) state_next = ST_RUN;
            ST_SLEEP: if (any_pending) state_next = ST_RUN;
            ST_DUMMY: if (cycle_end && dummy_cnt_reg == 2'd1) state_next = ST_RUN;
            default: state_next = ST_RUN;
        endcase
    end

    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= ST_RUN;
            instr_reg <= 14'h0000;
            pc_reg <= {PC_W{1'b0}};
            pgm_addr_reg <= {PC_W{1'b0}};
            wreg_reg <= 8'h00;
            timeout_status_bit_reg <= 1'b1;
            powerdown_status_bit_reg <= 1'b1;
            file_addr_reg <= 7'h00;
            file_wdata_reg <= 8'h00;
            file_we_reg <= 1'b0;
            file_re_reg <= 1'b0;
            port_ref_update_reg <= 1'b0;
            watchdog_clear_reg <= 1'b0;
            osc_driver_on_reg <= 1'b1;
            vector_pending_reg <= 1'b0;
            dummy_cnt_reg <= 2'd0;
            irq_sampled_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            file_we_reg <= 1'b0;
            file_re_reg <= 1'b0;
            port_ref_update_reg <= 1'b0;
            watchdog_clear_reg <= 1'b0;
            // The pending condition is frozen on the first quarter, so the
            // no-op versus sleep decision cannot race a late flag.
            if (phase == 2'd0 && osc_driver_on_reg) begin
                irq_sampled_reg <= any_pending && !ctrl_reg[`CESW_CTRL_GIE];
            end
            if (state_reg == ST_RUN && !pgm_mode && ctrl_reg[`CESW_CTRL_RUN]) begin
                if (phase == 2'd0 && names_file) begin
                    file_addr_reg <= f_addr;
                    file_re_reg <= 1'b1;
                    if (is_clrf && f_addr == UPPER_PORT_ADDR) begin
                        port_ref_update_reg <= 1'b1;
                    end
                end
                if (cycle_end) begin
                    if (names_file && !is_skip_bit && category != 2'b01 ? 1'b1 : 1'b0) begin
                        if (dest_sel || instr_reg[11:8] == 4'h0) begin
                            file_wdata_reg <= alu_res;
                            file_we_reg <= 1'b1;
                        end else begin
                            wreg_reg <= alu_res;
                        end
                    end else if (category == 2'b01 && !is_skip_bit) begin
                        file_wdata_reg <= alu_res;
                        file_we_reg <= 1'b1;
                    end else if (category == 2'b11) begin
                        wreg_reg <= lit8;
                    end else if (instr_reg == 14'h0100) begin
                        wreg_reg <= 8'h00;
                    end
                    if (is_sleep && irq_sampled_reg) begin
                        // Executes as a no-operation; flags stay untouched.
                        instr_reg <= pgm_rdata;
                        pc_reg <= pc_reg + 1'b1;
                        pgm_addr_reg <= pc_reg + 1'b1;
                    end else if (is_sleep) begin
                        watchdog_clear_reg <= 1'b1;
                        timeout_status_bit_reg <= 1'b1;
                        powerdown_status_bit_reg <= 1'b0;
                        osc_driver_on_reg <= 1'b0;
                        instr_reg <= pgm_rdata;
                        pc_reg <= pc_reg + 1'b1;
                        pgm_addr_reg <= pc_reg + 1'b1;
                        vector_pending_reg <= ctrl_reg[`CESW_CTRL_GIE];
                    end else if (vector_pending_reg) begin
                        vector_pending_reg <= 1'b0;
                        pc_reg <= `CESW_INT_VEC;
                        pgm_addr_reg <= `CESW_INT_VEC;
                        instr_reg <= 14'h0000;
                        state_reg <= ST_DUMMY;
                        dummy_cnt_reg <= 2'd0;
                    end else if (is_goto_call) begin
                        pc_reg <= {{(PC_W-11){1'b0}}, lit11};
                        pgm_addr_reg <= {{(PC_W-11){1'b0}}, lit11};
                        instr_reg <= 14'h0000;
                    end else if (pc_change) begin
                        pc_reg <= pc_reg + 1'b1;
                        pgm_addr_reg <= pc_reg + 1'b1;
                        instr_reg <= 14'h0000;
                    end else begin
                        instr_reg <= pgm_rdata;
                        pc_reg <= pc_reg + 1'b1;
                        pgm_addr_reg <= pc_reg + 1'b1;
                    end
                    if (is_watchdog_clear_instruction) begin
                        watchdog_clear_reg <= 1'b1;
                        timeout_status_bit_reg <= 1'b1;
                        powerdown_status_bit_reg <= 1'b1;
                    end
                end
            end else if (state_reg == ST_IDLE && cycle_end) begin
                instr_reg <= pgm_rdata;
                pc_reg <= pc_reg + 1'b1;
                pgm_addr_reg <= pc_reg + 1'b1;
            end else if (state_reg == ST_DUMMY && cycle_end) begin
                dummy_cnt_reg <= dummy_cnt_reg + 2'd1;
                if (dummy_cnt_reg == 2'd1) begin
                    instr_reg <= pgm_rdata;
                    pc_reg <= pc_reg + 1'b1;
                    pgm_addr_reg <= pc_reg + 1'b1;
                end
            end else if (state_reg == ST_SLEEP && any_pending) begin
                osc_driver_on_reg <= 1'b1;
            end
            if (pgm_mode) begin
                pgm_addr_reg <= pgm_peek_reg;
            end
        end
    end

    // ****************************************************************
    // APB slave, identity words and interrupt status
    // ****************************************************************
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;
    assign mapped = (paddr <= `CESW_OFF_PGMDATA) && (paddr[1:0] == 2'b00);
    assign pslverr = psel && penable && !mapped;
    assign irq = |(irq_stat_reg & irq_mask_reg);

    always @* begin
        ev_set = 4'h0;
        ev_set[`CESW_IRQ_WAKE] = (state_reg == ST_SLEEP) && any_pending;
        ev_set[`CESW_IRQ_SLEEP] = (state_reg == ST_RUN) && (state_next == ST_SLEEP);
        ev_set[`CESW_IRQ_NOPSL] = (state_reg == ST_RUN) && cycle_end && is_sleep &&
                                  irq_sampled_reg && ctrl_reg[`CESW_CTRL_RUN] && !pgm_mode;
        ev_set[`CESW_IRQ_W] = 1'b0;
    end

    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ctrl_reg <= `CESW_CTRL_RESET;
            irq_stat_reg <= 4'h0;
            irq_mask_reg <= 4'h0;
            id_addr_reg <= 2'd0;
            pgm_peek_reg <= {PC_W{1'b0}};
            prdata <= 32'h0000_0000;
            for (i = 0; i < 4; i = i + 1) begin
                id_mem[i] <= 4'h0;
            end
        end else begin
            // Set wins over a write-one clear in the same cycle.
            irq_stat_reg <= (irq_stat_reg & ~((wr_en && paddr == `CESW_OFF_IRQ_STAT) ?
                            pwdata[3:0] : 4'h0)) | ev_set;
            if (wr_en) begin
                case (paddr)
                    `CESW_OFF_CTRL: ctrl_reg <= {28'h000_0000, pwdata[3:0]};
                    `CESW_OFF_IRQ_MASK: irq_mask_reg <= pwdata[3:0];
                    `CESW_OFF_IDADDR: id_addr_reg <= pwdata[1:0];
                    `CESW_OFF_PGMADDR: pgm_peek_reg <= pwdata[PC_W-1:0];
                    `CESW_OFF_IDDATA: if (pgm_mode) id_mem[id_addr_reg] <= pwdata[3:0];
                    default: ctrl_reg <= ctrl_reg;
                endcase
            end
            if (rd_en) begin
                case (paddr)
                    `CESW_OFF_CTRL: prdata <= ctrl_reg;
                    `CESW_OFF_STATUS: prdata <= {29'h0000_0000, state_reg == ST_SLEEP,
                                                 powerdown_status_bit_reg,
                                                 timeout_status_bit_reg};
                    `CESW_OFF_IRQ_STAT: prdata <= {28'h000_0000, irq_stat_reg};
                    `CESW_OFF_IRQ_MASK: prdata <= {28'h000_0000, irq_mask_reg};
                    `CESW_OFF_INSTR: prdata <= {18'h0_0000, instr_reg};
                    `CESW_OFF_WREG: prdata <= {24'h00_0000, wreg_reg};
                    `CESW_OFF_PC: prdata <= {{(32-PC_W){1'b0}}, pc_reg};
                    `CESW_OFF_IDADDR: prdata <= {30'h0000_0000, id_addr_reg};
                    `CESW_OFF_IDDATA: prdata <= pgm_mode ? {28'h000_0000, id_mem[id_addr_reg]}
                                                         : 32'h0000_0000;
                    `CESW_OFF_PGMADDR: prdata <= {{(32-PC_W){1'b0}}, pgm_peek_reg};
                    `CESW_OFF_PGMDATA: prdata <= (pgm_mode && !ctrl_reg[`CESW_CTRL_CP]) ?
                                                 {18'h0_0000, pgm_rdata} : 32'h0000_0000;
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ===== verification/cesw_ctrl_chk.sv
// Port-level assertions for the execution, sleep and register controller.
// Bound to cesw_core_ctrl; a single clock domain on mclk.
`timescale 1ns/1ps
`default_nettype none
module cesw_ctrl_chk #(
    parameter PC_W = 13,
    parameter UPPER_PORT_ADDR = 7'h06
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [PC_W-1:0] pgm_addr_reg,
    input wire logic [6:0] file_addr_reg,
    input wire logic file_we_reg,
    input wire logic file_re_reg,
    input wire logic port_ref_update_reg,
    input wire logic watchdog_clear_reg,
    input wire logic osc_driver_on_reg
);
    // ********************************
    // Assertions
    // ********************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    a_zero_wait: assert property (psel && penable |-> pready)
        else $error("slave inserted a wait state");
    a_unmapped_err: assert property (psel && penable && paddr > 12'h028 |-> pslverr)
        else $error("unmapped access not refused");
    a_refused_zero: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
        else $error("refused read returned data");
    a_cycle_spacing: assert property (file_we_reg |=> !file_we_reg [*3])
        else $error("stores closer than one instruction cycle");
    a_read_first: assert property (file_we_reg |->
        $past(file_re_reg) || $past(file_re_reg, 2) || $past(file_re_reg, 3))
        else $error("file store without a preceding read");
    a_port_ref: assert property (port_ref_update_reg |-> file_addr_reg == UPPER_PORT_ADDR)
        else $error("change reference refreshed for another address");
    a_halt_quiet: assert property (!osc_driver_on_reg |-> !file_we_reg && !file_re_reg)
        else $error("file access while the clock is stopped");
    a_fetch_held: assert property (!osc_driver_on_reg && !$past(osc_driver_on_reg)
        |-> $stable(pgm_addr_reg)) else $error("fetch address moved while asleep");
    a_sleep_wdog: assert property ($fell(osc_driver_on_reg) |-> watchdog_clear_reg
        || $past(watchdog_clear_reg) || $past(watchdog_clear_reg, 2)
        || $past(watchdog_clear_reg, 3) || $past(watchdog_clear_reg, 4))
        else $error("sleep entered without clearing the watchdog");
    c_sleep: cover property ($fell(osc_driver_on_reg));
    c_wake: cover property ($rose(osc_driver_on_reg));
    c_port_ref: cover property (port_ref_update_reg);
endmodule
bind cesw_core_ctrl cesw_ctrl_chk #(.PC_W(PC_W), .UPPER_PORT_ADDR(UPPER_PORT_ADDR)) chk_inst (
    .mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pgm_addr_reg(pgm_addr_reg), .file_addr_reg(file_addr_reg), .file_we_reg(file_we_reg),
    .file_re_reg(file_re_reg), .port_ref_update_reg(port_ref_update_reg),
    .watchdog_clear_reg(watchdog_clear_reg), .osc_driver_on_reg(osc_driver_on_reg));
`default_nettype wire

// ===== verification/tb_top.sv
// Self-checking bench for the execution, sleep and register controller.
// Models program and file memory as combinational arrays; APB master here.
`timescale 1ns/1ps
`default_nettype none
`include "cesw_map.vh"
module tb_top;
    logic mclk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slv;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, rd;
    logic [7:0] ien = 8'h01, ipend = 8'h00;
    logic [13:0] pmem [0:7];
    logic [7:0] fmem [0:127];
    wire [31:0] prdata;
    wire pready, pslverr, irq, wdc, osc_on, fwe, fre, pref;
    wire [12:0] pga;
    wire [6:0] fa;
    wire [7:0] fwd;
    int miscompares = 0, checks = 0, cyc = 0, i;
    logic saw_pref;
    cesw_core_ctrl cesw_core_ctrl_inst (.mclk(mclk), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .pgm_rdata(pmem[pga[2:0]]),
        .pgm_addr_reg(pga), .file_rdata(fmem[fa]), .file_addr_reg(fa), .file_wdata_reg(fwd),
        .file_we_reg(fwe), .file_re_reg(fre), .port_ref_update_reg(pref),
        .int_enable_flags(ien), .int_pending_flags(ipend), .watchdog_clear_reg(wdc),
        .osc_driver_on_reg(osc_on));
    // ********************************
    // Bench
    // ********************************
    always #2 mclk = ~mclk;
    always @(posedge mclk) begin
        if (fwe) fmem[fa] <= fwd;
        if (pref) saw_pref <= 1'b1;
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input string name, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(name, rd, exp);
    endtask
    task automatic start(input logic [31:0] ctrl, input logic [7:0] pend);
        nrst <= 1'b0;
        ipend <= pend;
        saw_pref = 1'b0;
        foreach (fmem[k]) fmem[k] = 8'h00;
        fmem[7'h20] = 8'h41;
        fmem[7'h06] = 8'h5a;
        repeat (5) @(posedge mclk);
        nrst <= 1'b1;
        apb(1'b1, `CESW_OFF_CTRL, ctrl);
    endtask
    task automatic wosc(input logic v);
        for (i = 0; i < 500 && osc_on !== v; i++) @(posedge mclk);
    endtask
    // ********************************
    // Tests
    // ********************************
    initial begin
        // Address 4 is reached only through the vector, the GOTO at 3 skips it.
        pmem = '{14'h0aa0, 14'h0a20, 14'h15a1, 14'h2805, 14'h0aa2, 14'h0186, 14'h0063, 14'h2807};
        start(32'h1, 8'h00);
        rdchk("status", `CESW_OFF_STATUS, 32'h3);
        wosc(1'b0);
        chk("osc", 32'(osc_on), 32'h0);
        chk("f20", 32'(fmem[7'h20]), 32'h42);
        rdchk("wreg", `CESW_OFF_WREG, 32'h43);
        chk("f21", 32'(fmem[7'h21]), 32'h8);
        chk("f06", 32'(fmem[7'h06]), 32'h0);
        chk("pref", 32'(saw_pref), 32'h1);
        chk("f22", 32'(fmem[7'h22]), 32'h0);
        rdchk("asleep", `CESW_OFF_STATUS, 32'h5);
        apb(1'b1, `CESW_OFF_IRQ_MASK, 32'h7);
        @(posedge mclk);
        chk("irq", 32'(irq), 32'h1);
        ipend <= 8'h01;
        wosc(1'b1);
        repeat (40) @(posedge mclk);
        for (i = 0; i < 8 && pga !== 13'h7; i++) @(posedge mclk);
        chk("inline", 32'(pga), 32'h7);
        chk("novec", 32'(fmem[7'h22]), 32'h0);
        rdchk("woke", `CESW_OFF_STATUS, 32'h1);
        rdchk("istat", `CESW_OFF_IRQ_STAT, 32'h3);
        apb(1'b1, `CESW_OFF_IRQ_STAT, 32'h3);
        rdchk("w1c", `CESW_OFF_IRQ_STAT, 32'h0);
        chk("irqoff", 32'(irq), 32'h0);
        start(32'h1, 8'h01);
        repeat (80) @(posedge mclk);
        chk("nopsl", 32'(osc_on), 32'h1);
        rdchk("nopst", `CESW_OFF_STATUS, 32'h3);
        rdchk("nopirq", `CESW_OFF_IRQ_STAT, 32'h4);
        start(32'h3, 8'h00);
        wosc(1'b0);
        ipend <= 8'h01;
        for (i = 0; i < 300 && fmem[7'h22] !== 8'h01; i++) @(posedge mclk);
        chk("vector", 32'(fmem[7'h22]), 32'h1);
        start(32'h4, 8'h00);
        apb(1'b1, `CESW_OFF_IDADDR, 32'h2);
        apb(1'b1, `CESW_OFF_IDDATA, 32'hff);
        rdchk("id", `CESW_OFF_IDDATA, 32'hf);
        apb(1'b1, `CESW_OFF_PGMADDR, 32'h3);
        rdchk("verify", `CESW_OFF_PGMDATA, 32'h2805);
        apb(1'b1, `CESW_OFF_CTRL, 32'hc);
        rdchk("prot", `CESW_OFF_PGMDATA, 32'h0);
        apb(1'b1, `CESW_OFF_CTRL, 32'h0);
        rdchk("idrun", `CESW_OFF_IDDATA, 32'h0);
        rdchk("unmap", 12'h040, 32'h0);
        chk("slverr", 32'(slv), 32'h1);
        tally_and_finish();
    end
endmodule
`default_nettype wire
